// *** inc/lacfg_pkg.sv ***
// shared constants and types for the lane a3 configuration register bank
package lacfg_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_QUIET_SPEED = 8'h40;
    localparam logic [7:0] OFS_EQUALIZER   = 8'h41;
    localparam logic [7:0] OFS_SWING       = 8'h42;
    localparam logic [7:0] OFS_DEEMPH      = 8'h43;
    localparam logic [7:0] OFS_THRESHOLD   = 8'h44;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_QUIET_SPEED = 8'h00;
    localparam logic [7:0] RST_EQUALIZER   = 8'h20;
    localparam logic [7:0] RST_SWING       = 8'h03;
    localparam logic [7:0] RST_DEEMPH      = 8'h03;
    localparam logic [7:0] RST_THRESHOLD   = 8'h00;

    // ------------------------------------------------------------
    // writable bit masks, reserved bits held at zero
    // ------------------------------------------------------------
    localparam logic [7:0] MSK_QUIET_SPEED = 8'h33;
    localparam logic [7:0] MSK_EQUALIZER   = 8'h3F;
    localparam logic [7:0] MSK_SWING       = 8'h7F;
    localparam logic [7:0] MSK_DEEMPH      = 8'hFF;
    localparam logic [7:0] MSK_THRESHOLD   = 8'h0F;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_IDLE_AUTO  = 5;
    localparam int POS_IDLE_FORCE = 4;
    localparam int POS_RATE_AUTO  = 1;
    localparam int POS_RATE_FORCE = 0;
    localparam int POS_EQ_ENABLE  = 5;
    localparam int POS_DEEMPH_TYPE = 7;

    // ------------------------------------------------------------
    // equalizer codes
    // ------------------------------------------------------------
    localparam logic [5:0] EQ_BYPASS = 6'h20;
    localparam logic [5:0] EQ_CODE0  = 6'h2A;
    localparam logic [5:0] EQ_CODE1  = 6'h30;
    localparam logic [5:0] EQ_CODE2  = 6'h32;
    localparam logic [5:0] EQ_CODE3  = 6'h39;
    localparam logic [5:0] EQ_CODE4  = 6'h35;
    localparam logic [5:0] EQ_CODE5  = 6'h37;
    localparam logic [5:0] EQ_CODE6  = 6'h3B;
    localparam logic [5:0] EQ_CODE7  = 6'h3D;

    // ------------------------------------------------------------
    // swing codes
    // ------------------------------------------------------------
    localparam logic [6:0] SW_600  = 7'h03;
    localparam logic [6:0] SW_800  = 7'h07;
    localparam logic [6:0] SW_1000 = 7'h0F;
    localparam logic [6:0] SW_1200 = 7'h1F;
    localparam logic [6:0] SW_1400 = 7'h3F;

    // ------------------------------------------------------------
    // de-emphasis codes
    // ------------------------------------------------------------
    localparam logic [7:0] DE_C_0P0  = 8'h01;
    localparam logic [7:0] DE_C_3P5  = 8'h03;
    localparam logic [7:0] DE_C_6P0  = 8'h05;
    localparam logic [7:0] DE_E_6P0  = 8'h88;
    localparam logic [7:0] DE_E_9P0  = 8'h90;
    localparam logic [7:0] DE_E_12P0 = 8'hA0;
    localparam logic [7:0] DE_RSVD   = 8'hC0;

    typedef enum logic [2:0] {
        LACFG_SW_600  = 3'b000,
        LACFG_SW_800  = 3'b001,
        LACFG_SW_1000 = 3'b010,
        LACFG_SW_1200 = 3'b011,
        LACFG_SW_1400 = 3'b100,
        LACFG_SW_BAD  = 3'b111
    } lacfg_swing_t;

    typedef enum logic [2:0] {
        LACFG_DE_0P0  = 3'b000,
        LACFG_DE_3P5  = 3'b001,
        LACFG_DE_6P0  = 3'b010,
        LACFG_DE_9P0  = 3'b011,
        LACFG_DE_12P0 = 3'b100,
        LACFG_DE_BAD  = 3'b111
    } lacfg_deemph_t;

    // register access request from the management bus engine
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lacfg_req_t;

    // decoded lane settings to the analog path
    typedef struct packed {
        logic          idle_auto;
        logic          output_muted;
        logic          signal_detect_en;
        logic          rate_auto;
        logic          rate_high;
        logic          eq_enable;
        logic          eq_bypass;
        logic          eq_valid;
        logic [2:0]    eq_index;
        logic [1:0]    gain_stage_field;
        logic [2:0]    boost_level_field;
        lacfg_swing_t  output_swing;
        logic          deemphasis_type_bit;
        lacfg_deemph_t deemph_level;
        logic [1:0]    thr_deassert;
        logic [1:0]    thr_assert;
    } lacfg_set_t;

endpackage

// *** design/lacfg_decode.sv ***
// lane setting decoder: register images to analog control codes
`timescale 1ns/10ps
`default_nettype none

module lacfg_decode
    import lacfg_pkg::*;
(
    input  wire logic [7:0]          quiet_speed,
    input  wire logic [7:0]          equalizer,
    input  wire logic [7:0]          swing,
    input  wire logic [7:0]          deemph,
    input  wire logic [7:0]          threshold,
    output lacfg_pkg::lacfg_set_t    settings
);
    import lacfg_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        settings = '0;
        // reserved bits never reach the decode
        settings.idle_auto = quiet_speed[POS_IDLE_AUTO];
        // forced idle: 0 mutes, 1 keeps output on
        settings.output_muted = !quiet_speed[POS_IDLE_AUTO]
                                && !quiet_speed[POS_IDLE_FORCE];
        settings.signal_detect_en = quiet_speed[POS_IDLE_AUTO];
        settings.rate_auto = quiet_speed[POS_RATE_AUTO];
        // forced rate: 0 is 2.5, 1 is 5.0 Gbps
        settings.rate_high = !quiet_speed[POS_RATE_AUTO]
                             && quiet_speed[POS_RATE_FORCE];

        // field split
        settings.eq_enable         = equalizer[POS_EQ_ENABLE];
        settings.gain_stage_field  = equalizer[4:3];
        settings.boost_level_field = equalizer[2:0];
        // reset code acts as bypass
        settings.eq_bypass = (equalizer[5:0] == EQ_BYPASS);
        settings.eq_valid  = 1'b1;
        // pin-equivalent settings
        unique case (equalizer[5:0])
            EQ_BYPASS: settings.eq_index = 3'h0;
            EQ_CODE0:  settings.eq_index = 3'h0;
            EQ_CODE1:  settings.eq_index = 3'h1;
            EQ_CODE2:  settings.eq_index = 3'h2;
            EQ_CODE3:  settings.eq_index = 3'h3;
            EQ_CODE4:  settings.eq_index = 3'h4;
            EQ_CODE5:  settings.eq_index = 3'h5;
            EQ_CODE6:  settings.eq_index = 3'h6;
            EQ_CODE7:  settings.eq_index = 3'h7;
            default: begin
                settings.eq_index = 3'h0;
                settings.eq_valid = 1'b0;
            end
        endcase

        // swing ladder
        unique case (swing[6:0])
            SW_600:  settings.output_swing = LACFG_SW_600;
            SW_800:  settings.output_swing = LACFG_SW_800;
            SW_1000: settings.output_swing = LACFG_SW_1000;
            SW_1200: settings.output_swing = LACFG_SW_1200;
            SW_1400: settings.output_swing = LACFG_SW_1400;
            default: settings.output_swing = LACFG_SW_BAD;
        endcase

        // type bit and level
        settings.deemphasis_type_bit = deemph[POS_DEEMPH_TYPE];
        unique case (deemph)
            DE_C_0P0:  settings.deemph_level = LACFG_DE_0P0;
            DE_C_3P5:  settings.deemph_level = LACFG_DE_3P5;
            DE_C_6P0:  settings.deemph_level = LACFG_DE_6P0;
            DE_E_6P0:  settings.deemph_level = LACFG_DE_6P0;
            DE_E_9P0:  settings.deemph_level = LACFG_DE_9P0;
            DE_E_12P0: settings.deemph_level = LACFG_DE_12P0;
            // reserved code flagged, not trusted
            default:   settings.deemph_level = LACFG_DE_BAD;
        endcase

        // threshold pair
        settings.thr_deassert = threshold[3:2];
        settings.thr_assert   = threshold[1:0];
    end

endmodule

`default_nettype wire

// *** design/lacfg_regs.sv ***
// lane a3 configuration register bank with management bus access port
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module lacfg_regs
    import lacfg_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire lacfg_pkg::lacfg_req_t req,
    output logic                      ack,
    output logic                      hit,
    output logic [7:0]                rdata,
    output lacfg_pkg::lacfg_set_t     settings
);
    import lacfg_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] quiet_speed_reg;
    logic [7:0] quiet_speed_next;
    logic [7:0] equalizer_reg;
    logic [7:0] equalizer_next;
    logic [7:0] swing_reg;
    logic [7:0] swing_next;
    logic [7:0] deemph_reg;
    logic [7:0] deemph_next;
    logic [7:0] threshold_reg;
    logic [7:0] threshold_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic       hit_next;
    logic       ack_reg;
    logic       ack_next;
    logic       mapped;

    assign mapped = (req.addr >= OFS_QUIET_SPEED)
                    && (req.addr <= OFS_THRESHOLD);

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        quiet_speed_next = quiet_speed_reg;
        equalizer_next   = equalizer_reg;
        swing_next       = swing_reg;
        deemph_next      = deemph_reg;
        threshold_next   = threshold_reg;
        rdata_next       = rdata_reg;
        hit_next         = hit_reg;
        ack_next         = req.write || req.read;
        if (req.write || req.read) begin
            hit_next = mapped;
        end
        // reserved bits masked to zero on write
        if (req.write) begin
            unique case (req.addr)
                OFS_QUIET_SPEED:
                    quiet_speed_next = req.wdata & MSK_QUIET_SPEED;
                OFS_EQUALIZER:
                    equalizer_next = req.wdata & MSK_EQUALIZER;
                OFS_SWING:
                    swing_next = req.wdata & MSK_SWING;
                OFS_DEEMPH:
                    deemph_next = req.wdata & MSK_DEEMPH;
                OFS_THRESHOLD:
                    threshold_next = req.wdata & MSK_THRESHOLD;
                default: ;
            endcase
        end
        // unmapped reads return zero
        if (req.read) begin
            unique case (req.addr)
                OFS_QUIET_SPEED: rdata_next = quiet_speed_reg;
                OFS_EQUALIZER:   rdata_next = equalizer_reg;
                OFS_SWING:       rdata_next = swing_reg;
                OFS_DEEMPH:      rdata_next = deemph_reg;
                OFS_THRESHOLD:   rdata_next = threshold_reg;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quiet_speed_reg <= RST_QUIET_SPEED;
            equalizer_reg   <= RST_EQUALIZER;
            swing_reg       <= RST_SWING;
            deemph_reg      <= RST_DEEMPH;
            threshold_reg   <= RST_THRESHOLD;
            rdata_reg       <= 8'h00;
            hit_reg         <= 1'b0;
            ack_reg         <= 1'b0;
        end else begin
            quiet_speed_reg <= quiet_speed_next;
            equalizer_reg   <= equalizer_next;
            swing_reg       <= swing_next;
            deemph_reg      <= deemph_next;
            threshold_reg   <= threshold_next;
            rdata_reg       <= rdata_next;
            hit_reg         <= hit_next;
            ack_reg         <= ack_next;
        end
    end

    assign ack   = ack_reg;
    assign hit   = hit_reg;
    assign rdata = rdata_reg;

    // ------------------------------------------------------------
    // lane setting decode
    // ------------------------------------------------------------
    lacfg_decode u_decode (
        .quiet_speed (quiet_speed_reg),
        .equalizer   (equalizer_reg),
        .swing       (swing_reg),
        .deemph      (deemph_reg),
        .threshold   (threshold_reg),
        .settings    (settings)
    );

endmodule

`default_nettype wire

// *** tb/lacfg_regs_assertions.sv ***
// concurrent checks on the lane a3 register bank ports
`timescale 1ns/10ps
`default_nettype none
module lacfg_regs_assertions (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire lacfg_pkg::lacfg_req_t req,
    input wire logic                  ack,
    input wire logic                  hit,
    input wire logic [7:0]            rdata,
    input wire lacfg_pkg::lacfg_set_t settings
);
    import lacfg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // access steps
    // ----------------------------------------
    sequence access_seen;
        req.write || req.read;
    endsequence
    sequence wr_to(logic [7:0] a);
        req.write && req.addr == a;
    endsequence
    sequence wr_val(logic [7:0] a, logic [7:0] v);
        wr_to(a) ##0 (req.wdata == v);
    endsequence
    idle_force_a: assert property (wr_to(OFS_QUIET_SPEED) |=>
        settings.idle_auto == $past(req.wdata[5]) && settings.output_muted
        == (!$past(req.wdata[5]) && !$past(req.wdata[4])))
        else $error("idle decode wrong");
    rate_select_a: assert property (wr_to(OFS_QUIET_SPEED) |=>
        settings.rate_high == (!$past(req.wdata[1]) && $past(req.wdata[0])))
        else $error("rate decode wrong");
    eq_fields_a: assert property (wr_to(OFS_EQUALIZER) |=>
        {settings.eq_enable, settings.gain_stage_field,
         settings.boost_level_field} == $past(req.wdata[5:0]))
        else $error("equalizer fields wrong");
    eq_bypass_a: assert property (wr_to(OFS_EQUALIZER) |=>
        settings.eq_bypass == ($past(req.wdata[5:0]) == EQ_BYPASS))
        else $error("bypass decode wrong");
    eq_top_code_a: assert property (wr_val(OFS_EQUALIZER, 8'h3D)
        |=> settings.eq_valid && settings.eq_index == 3'h7)
        else $error("equalizer code not accepted");
    swing_top_a: assert property (wr_to(OFS_SWING) ##0
        (req.wdata[6:0] == SW_1400) |=> settings.output_swing == LACFG_SW_1400)
        else $error("swing decode wrong");
    deemph_type_a: assert property (wr_to(OFS_DEEMPH) |=>
        settings.deemphasis_type_bit == $past(req.wdata[7]))
        else $error("de-emphasis type wrong");
    compat_six_a: assert property (wr_val(OFS_DEEMPH, DE_C_6P0)
        |=> settings.deemph_level == LACFG_DE_6P0)
        else $error("compatibility level wrong");
    enh_twelve_a: assert property (wr_val(OFS_DEEMPH, DE_E_12P0)
        |=> settings.deemph_level == LACFG_DE_12P0)
        else $error("enhanced level wrong");
    threshold_a: assert property (wr_to(OFS_THRESHOLD) |=>
        {settings.thr_deassert, settings.thr_assert} == $past(req.wdata[3:0]))
        else $error("threshold fields wrong");
    reset_vals_a: assert property ($fell(rst) |->
        settings.eq_bypass && settings.output_swing == LACFG_SW_600
        && settings.deemph_level == LACFG_DE_3P5)
        else $error("settings after reset wrong");
    // ack is a single pulse, one cycle after each strobe
    ack_pulse_a: assert property (ack == $past(req.write || req.read))
        else $error("ack timing wrong");
    hit_map_a: assert property (access_seen |=>
        hit == ($past(req.addr) >= OFS_QUIET_SPEED
                && $past(req.addr) <= OFS_THRESHOLD))
        else $error("hit flag wrong");
    rdata_hold_a: assert property (!req.read |=> $stable(rdata))
        else $error("read data moved");
endmodule
bind lacfg_regs lacfg_regs_assertions u_chk (.clock(clock), .rst(rst),
    .req(req), .ack(ack), .hit(hit), .rdata(rdata), .settings(settings));
`default_nettype wire

// *** tb/lacfg_host_model.sv ***
// management host model issuing single byte register accesses
`timescale 1ns/10ps
`default_nettype none
module lacfg_host_model (
    input  wire logic                 clock,
    output var lacfg_pkg::lacfg_req_t req,
    input  wire logic                 ack,
    input  wire logic [7:0]           rdata
);
    import lacfg_pkg::*;
    initial req = '0;
    function automatic logic [7:0] keep(input logic [7:0] a);
        case (a)
            OFS_QUIET_SPEED: keep = MSK_QUIET_SPEED;
            OFS_EQUALIZER:   keep = MSK_EQUALIZER;
            OFS_SWING:       keep = MSK_SWING;
            OFS_THRESHOLD:   keep = MSK_THRESHOLD;
            default:         keep = 8'hFF;
        endcase
    endfunction
    // one strobe pulse; holding it would repeat the access
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{write: w, read: !w, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
        #1;
        while (ack !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        q = rdata;
    endtask
    // raw lets a scenario break the reserved-bit habit on purpose
    task automatic wr(input logic [7:0] a, d, input logic raw);
        logic [7:0] q;
        if (!raw && a == OFS_DEEMPH && d == DE_RSVD) return;
        xfer(1'b1, a, raw ? d : d & keep(a), q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the lane a3 configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import lacfg_pkg::*;
    localparam logic [7:0] OFS [5] = '{OFS_QUIET_SPEED, OFS_EQUALIZER,
        OFS_SWING, OFS_DEEMPH, OFS_THRESHOLD};
    localparam logic [7:0] RSTV [5] = '{RST_QUIET_SPEED, RST_EQUALIZER,
        RST_SWING, RST_DEEMPH, RST_THRESHOLD};
    localparam logic [5:0] EQC [9] = '{EQ_BYPASS, EQ_CODE0, EQ_CODE1,
        EQ_CODE2, EQ_CODE3, EQ_CODE4, EQ_CODE5, EQ_CODE6, EQ_CODE7};
    localparam logic [6:0] SWC [5] = '{SW_600, SW_800, SW_1000, SW_1200,
        SW_1400};
    localparam lacfg_swing_t SWE [5] = '{LACFG_SW_600, LACFG_SW_800,
        LACFG_SW_1000, LACFG_SW_1200, LACFG_SW_1400};
    localparam logic [7:0] DEC [6] = '{DE_C_0P0, DE_C_3P5, DE_C_6P0,
        DE_E_6P0, DE_E_9P0, DE_E_12P0};
    localparam lacfg_deemph_t DEE [6] = '{LACFG_DE_0P0, LACFG_DE_3P5,
        LACFG_DE_6P0, LACFG_DE_6P0, LACFG_DE_9P0, LACFG_DE_12P0};
    logic       clock;
    logic       rst;
    lacfg_req_t req;
    logic       ack;
    logic       hit;
    logic [7:0] rdata;
    logic [7:0] q;
    lacfg_set_t settings;
    int         fails;
    int         cmp_count;
    lacfg_regs DUT (.clock(clock), .rst(rst), .req(req), .ack(ack),
        .hit(hit), .rdata(rdata), .settings(settings));
    lacfg_host_model host (.clock(clock), .req(req), .ack(ack),
        .rdata(rdata));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string name, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset;
        for (int k = 0; k < 5; k++) begin
            host.rd(OFS[k], q);
            chk("reset value", q, RSTV[k]);
            chk("mapped hit", hit, 1'b1);
            chk("ack", ack, 1'b1);
        end
        @(posedge clock);
        #1;
        chk("ack low", ack, 1'b0);
        chk("bypass", settings.eq_bypass, 1'b1);
        chk("swing", settings.output_swing, LACFG_SW_600);
        chk("level", settings.deemph_level, LACFG_DE_3P5);
    endtask
    task automatic t_idle_rate;
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {2'b00, i[3], i[2], 2'b00, i[1], i[0]};
            host.wr(OFS_QUIET_SPEED, d, 1'b0);
            chk("idle auto", settings.idle_auto, i[3]);
            chk("muted", settings.output_muted, !i[3] && !i[2]);
            chk("detect", settings.signal_detect_en, i[3]);
            chk("rate auto", settings.rate_auto, i[1]);
            chk("rate high", settings.rate_high, !i[1] && i[0]);
        end
    endtask
    task automatic t_eq;
        for (int k = 0; k < 9; k++) begin
            host.wr(OFS_EQUALIZER, {2'b00, EQC[k]}, 1'b0);
            chk("enable", settings.eq_enable, 1'b1);
            chk("gain", settings.gain_stage_field, EQC[k][4:3]);
            chk("boost", settings.boost_level_field, EQC[k][2:0]);
            chk("bypass", settings.eq_bypass, k == 0);
            chk("eq valid", settings.eq_valid, 1'b1);
            chk("eq index", settings.eq_index, k == 0 ? 0 : k - 1);
        end
    endtask
    task automatic t_swing;
        for (int k = 0; k < 5; k++) begin
            host.wr(OFS_SWING, {1'b1, SWC[k]}, 1'b1);
            chk("swing", settings.output_swing, SWE[k]);
            host.rd(OFS_SWING, q);
            chk("swing read", q, {1'b0, SWC[k]});
        end
    endtask
    task automatic t_deemph;
        for (int k = 0; k < 6; k++) begin
            host.wr(OFS_DEEMPH, DEC[k], 1'b0);
            chk("type", settings.deemphasis_type_bit, DEC[k][7]);
            chk("level", settings.deemph_level, DEE[k]);
        end
        host.wr(OFS_DEEMPH, DE_RSVD, 1'b0);
        host.rd(OFS_DEEMPH, q);
        chk("kept level", q, DE_E_12P0);
    endtask
    task automatic t_thresh;
        for (int i = 0; i < 16; i++) begin
            host.wr(OFS_THRESHOLD, 8'hF0 | 8'(i), 1'b1);
            chk("deassert", settings.thr_deassert, i[3:2]);
            chk("assert", settings.thr_assert, i[1:0]);
            host.rd(OFS_THRESHOLD, q);
            chk("thr read", q, 8'(i));
        end
    endtask
    // undocumented codes are stored but flagged; reserved bits dropped
    task automatic t_odd;
        host.wr(OFS_QUIET_SPEED, 8'hFF, 1'b1);
        host.rd(OFS_QUIET_SPEED, q);
        chk("ctrl read", q, MSK_QUIET_SPEED);
        chk("idle auto", settings.idle_auto, 1'b1);
        chk("rate high", settings.rate_high, 1'b0);
        host.wr(OFS_EQUALIZER, 8'hFD, 1'b1);
        chk("eq index", settings.eq_index, 3'h7);
        host.rd(OFS_EQUALIZER, q);
        chk("eq read", q, {2'b00, EQ_CODE7});
        host.wr(OFS_EQUALIZER, 8'h21, 1'b0);
        chk("eq odd", settings.eq_valid, 1'b0);
        host.wr(OFS_SWING, 8'h01, 1'b0);
        chk("swing odd", settings.output_swing, LACFG_SW_BAD);
        host.wr(OFS_DEEMPH, 8'h7F, 1'b0);
        chk("level odd", settings.deemph_level, LACFG_DE_BAD);
    endtask
    task automatic t_unmapped;
        host.wr(8'h45, 8'hFF, 1'b1);
        chk("miss hit", hit, 1'b0);
        chk("miss keeps", settings.thr_assert, 2'h3);
        host.rd(8'h45, q);
        chk("miss data", q, 8'h00);
        host.rd(8'h3F, q);
        chk("low miss hit", hit, 1'b0);
        host.rd(OFS_SWING, q);
        chk("hit before reset", hit, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        #1;
        chk("reset ack", ack, 1'b0);
        chk("reset hit", hit, 1'b0);
        chk("reset data", rdata, 8'h00);
        @(posedge clock);
        rst <= 1'b0;
        t_reset();
    endtask
    initial begin
        #(25 * 5000);
        fails++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        fails = 0;
        cmp_count = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_idle_rate();
        t_eq();
        t_swing();
        t_deemph();
        t_thresh();
        t_odd();
        t_unmapped();
        test_done();
    end
endmodule
`default_nettype wire
